// [fcv_pkg.sv]
// fcv_pkg: constants for the channel 1 fuse configuration and drain-source result registers.
// assumes a 10 MHz device clock and a register port fed by the serial interface decoder.
// Notes on behaviour
// - result ready bit 10 is set by a new conversion, cleared by a read
// - bits 9..0 show the latest 10-bit drain-source conversion, read only
// - cool-down bits 15..14: indefinite, 0.8 s, 2.0 s, 4.0 s
// - cool-down code zero keeps the channel off until the host writes a timed cool-down code
// - delay bits 10..9 select 0.2, 0.4, 1.0 or 2.0 ms
// - timer starts over threshold; shutdown only if over for whole delay
// - threshold bits 8..7 select one of four current levels
// - trip energy bits 6..3 and nominal current bits 2..0 held and exported
// - writes to trip energy and nominal current ignored during cool-down
`default_nettype none
package fcv_pkg;
    localparam logic [7:0]  FCV_ADDR_RESULT  = 8'h14;
    localparam logic [7:0]  FCV_ADDR_CONFIG  = 8'h15;
    localparam logic [15:0] FCV_CONFIG_RESET = 16'h0000;
    localparam logic [4:0]  FCV_RESULT_RSVD  = 5'h1F;
    localparam int FCV_READY_BIT  = 10;
    localparam int FCV_CLDN_LSB   = 14;
    localparam int FCV_DLY_LSB    = 9;
    localparam int FCV_THR_LSB    = 7;
    localparam int FCV_TRIP_LSB   = 3;
    localparam int FCV_NOM_LSB    = 0;
    localparam int FCV_CLK_HZ     = 10_000_000;
    // times in microseconds
    localparam int FCV_DLY0_US    = 200;
    localparam int FCV_DLY1_US    = 400;
    localparam int FCV_DLY2_US    = 1000;
    localparam int FCV_DLY3_US    = 2000;
    localparam int FCV_DLY0_CYC   = FCV_DLY0_US * (FCV_CLK_HZ / 1_000_000);
    localparam int FCV_DLY1_CYC   = FCV_DLY1_US * (FCV_CLK_HZ / 1_000_000);
    localparam int FCV_DLY2_CYC   = FCV_DLY2_US * (FCV_CLK_HZ / 1_000_000);
    localparam int FCV_DLY3_CYC   = FCV_DLY3_US * (FCV_CLK_HZ / 1_000_000);
    // times in milliseconds
    localparam int FCV_CLDN1_MS   = 800;
    localparam int FCV_CLDN2_MS   = 2000;
    localparam int FCV_CLDN3_MS   = 4000;
    localparam int FCV_CLDN1_CYC  = FCV_CLDN1_MS * (FCV_CLK_HZ / 1000);
    localparam int FCV_CLDN2_CYC  = FCV_CLDN2_MS * (FCV_CLK_HZ / 1000);
    localparam int FCV_CLDN3_CYC  = FCV_CLDN3_MS * (FCV_CLK_HZ / 1000);

    typedef enum logic [1:0] {
        FCV_ON    = 2'b00,
        FCV_COOL  = 2'b01,
        FCV_HOLD  = 2'b10
    } fcv_state_t;
endpackage
`default_nettype wire

// [fcv_tmr_if.sv]
// fcv_tmr_if: delay timer request and result between top and timer module.
// assumes both ends on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface fcv_tmr_if;
    logic        over;
    logic [1:0]  sel;
    logic        trip;
    modport ctrl (output over, output sel, input trip);
    modport tmr  (input over, input sel, output trip);
endinterface
`default_nettype wire

// [fcv_dly_tmr.sv]
// fcv_dly_tmr: continuous over-threshold delay timer.
// assumes over is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module fcv_dly_tmr
(
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // timer port
    fcv_tmr_if.tmr    t
);
    logic [14:0] cnt_q;
    logic [14:0] lim;

    assign lim = (t.sel == 2'h0) ? 15'(fcv_pkg::FCV_DLY0_CYC) :
                 (t.sel == 2'h1) ? 15'(fcv_pkg::FCV_DLY1_CYC) :
                 (t.sel == 2'h2) ? 15'(fcv_pkg::FCV_DLY2_CYC) :
                                   15'(fcv_pkg::FCV_DLY3_CYC);
    // saturates at the limit so trip stays high while over persists
    assign t.trip = t.over && (cnt_q == lim);

    always_ff @(posedge clk)
    begin
        if (!nrst || !t.over)
            cnt_q <= 15'h0000;
        else if (cnt_q < lim)
            cnt_q <= cnt_q + 15'h0001;
    end

    AST_TRIP_NEEDS_RUN: assert property (@(posedge clk) disable iff (!nrst)
        t.trip |-> $past(t.over) && t.over)
        else $error("trip without continuous over-threshold");
    AST_CLEAR_ON_DROP: assert property (@(posedge clk) disable iff (!nrst)
        !t.over |=> cnt_q == 15'h0000)
        else $error("timer not cleared when current dropped");
endmodule // fcv_dly_tmr
`default_nettype wire

// [fcv_top.sv]
// fcv_top: channel 1 fuse protection config register and drain-source result register.
// assumes the serial decoder gives one-cycle rd/wr strobes with an 8-bit address.
`timescale 1ns/1ps
`default_nettype none
module fcv_top
#(
    parameter int CLDN1_CYC = fcv_pkg::FCV_CLDN1_CYC,
    parameter int CLDN2_CYC = fcv_pkg::FCV_CLDN2_CYC,
    parameter int CLDN3_CYC = fcv_pkg::FCV_CLDN3_CYC
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // register port from serial decoder
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // converter result, same clock
    input  wire logic [9:0]  conv_value,
    input  wire logic        conv_valid,
    // analog front end
    input  wire logic        over_threshold,
    input  wire logic        fuse_shutdown,
    // controls to channel logic
    output logic [1:0]       delayed_shutdown_threshold_select,
    output logic [3:0]       trip_energy_select,
    output logic [2:0]       nominal_current_select,
    output logic             delayed_shutdown_trip,
    output logic             channel_enable_allowed,
    output logic             in_cooldown
);
    logic [15:0]     cfg_q;
    logic [9:0]      val_q;
    logic            rdy_q;
    logic            ov_s1_q;
    logic            ov_s2_q;
    logic [25:0]     cool_q;
    fcv_pkg::fcv_state_t st_q;
    fcv_tmr_if       tif ();

    // one address compare shared by the strobes and the read mux
    function automatic logic fcv_hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    wire             hit_cfg  = fcv_hit(reg_addr, fcv_pkg::FCV_ADDR_CONFIG);
    wire             hit_res  = fcv_hit(reg_addr, fcv_pkg::FCV_ADDR_RESULT);
    wire             wr_cfg   = reg_wr && hit_cfg;
    wire             rd_res   = reg_rd && hit_res;
    wire [1:0]       cldn_sel = cfg_q[fcv_pkg::FCV_CLDN_LSB +: 2];
    wire             cooling  = (st_q != fcv_pkg::FCV_ON);
    wire [25:0]      cool_lim = (cldn_sel == 2'h1) ? 26'(CLDN1_CYC) :
                                (cldn_sel == 2'h2) ? 26'(CLDN2_CYC) :
                                                     26'(CLDN3_CYC);
    // trip and nominal fields frozen while cooling down
    wire [6:0]       low_keep = cooling ? cfg_q[6:0] : reg_wdata[6:0];
    wire [15:0]      cfg_d    = {reg_wdata[15:7], low_keep};
    wire [15:0]      res_word = {fcv_pkg::FCV_RESULT_RSVD, rdy_q, val_q};
    wire             shut_ev  = fuse_shutdown || tif.trip;

    assign tif.over = ov_s2_q;
    assign tif.sel  = cfg_q[fcv_pkg::FCV_DLY_LSB +: 2];
    assign delayed_shutdown_threshold_select = cfg_q[fcv_pkg::FCV_THR_LSB +: 2];
    assign trip_energy_select     = cfg_q[fcv_pkg::FCV_TRIP_LSB +: 4];
    assign nominal_current_select = cfg_q[fcv_pkg::FCV_NOM_LSB +: 3];
    assign delayed_shutdown_trip  = tif.trip;
    assign channel_enable_allowed = !cooling;
    assign in_cooldown            = cooling;
    assign reg_rdata = hit_cfg ? cfg_q :
                       hit_res ? res_word : 16'h0000;

    fcv_dly_tmr u_tmr
    (
        .clk  (clk),
        .nrst (nrst),
        .t    (tif)
    );

    always_ff @(posedge clk)
    begin
        ov_s1_q <= nrst & over_threshold;
        ov_s2_q <= nrst & ov_s1_q;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            cfg_q <= fcv_pkg::FCV_CONFIG_RESET;
        else if (wr_cfg)
            cfg_q <= cfg_d;
    end

    // new result wins over a clearing read in the same cycle
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            val_q <= 10'h000;
            rdy_q <= 1'b0;
        end
        else if (conv_valid)
        begin
            val_q <= conv_value;
            rdy_q <= 1'b1;
        end
        else if (rd_res)
            rdy_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_q   <= fcv_pkg::FCV_ON;
            cool_q <= 26'h0000000;
        end
        else
        begin
            case (st_q)
                fcv_pkg::FCV_ON:
                    if (shut_ev)
                    begin
                        cool_q <= 26'h0000000;
                        st_q   <= (cldn_sel == 2'h0) ? fcv_pkg::FCV_HOLD : fcv_pkg::FCV_COOL;
                    end
                fcv_pkg::FCV_COOL:
                    if (cool_q >= cool_lim - 26'h0000001)
                        st_q <= fcv_pkg::FCV_ON;
                    else
                        cool_q <= cool_q + 26'h0000001;
                fcv_pkg::FCV_HOLD:
                    // host must write a timed code before any retry
                    if (wr_cfg && reg_wdata[fcv_pkg::FCV_CLDN_LSB +: 2] != 2'h0)
                    begin
                        cool_q <= 26'h0000000;
                        st_q   <= fcv_pkg::FCV_COOL;
                    end
                default:
                    st_q <= fcv_pkg::FCV_ON;
            endcase
        end
    end

    // result register
    AST_READY_SET: assert property (@(posedge clk) disable iff (!nrst)
        conv_valid |=> rdy_q && val_q == $past(conv_value))
        else $error("ready flag or value not updated by conversion");
    AST_READY_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
        rd_res && !conv_valid |=> !rdy_q)
        else $error("ready flag not cleared by read");
    AST_READY_KEEP: assert property (@(posedge clk) disable iff (!nrst)
        !conv_valid && !rd_res |=> rdy_q == $past(rdy_q))
        else $error("ready flag changed with no event");
    AST_VALUE_KEEP: assert property (@(posedge clk) disable iff (!nrst)
        !conv_valid |=> val_q == $past(val_q))
        else $error("result value changed with no conversion");
    AST_RESULT_WORD: assert property (@(posedge clk) disable iff (!nrst)
        hit_res |-> reg_rdata == {fcv_pkg::FCV_RESULT_RSVD, rdy_q, val_q})
        else $error("result word mismatch");
    AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (!nrst)
        !hit_res && !hit_cfg |-> reg_rdata == 16'h0000)
        else $error("unmapped address read nonzero");
    AST_RESULT_RO: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && !reg_rd && hit_res && !conv_valid
        |=> val_q == $past(val_q) && rdy_q == $past(rdy_q))
        else $error("write changed the read-only result");

    // configuration register
    AST_WRITE_TAKES: assert property (@(posedge clk) disable iff (!nrst)
        wr_cfg && !cooling |=> cfg_q == $past(reg_wdata))
        else $error("config write lost");
    AST_CFG_KEEP: assert property (@(posedge clk) disable iff (!nrst)
        !wr_cfg |=> cfg_q == $past(cfg_q))
        else $error("config changed without a write");
    AST_LOCK_LOW: assert property (@(posedge clk) disable iff (!nrst)
        wr_cfg && cooling |=> cfg_q[6:0] == $past(cfg_q[6:0]))
        else $error("trip or nominal changed during cool-down");
    AST_LOCK_HIGH: assert property (@(posedge clk) disable iff (!nrst)
        wr_cfg && cooling |=> cfg_q[15:7] == $past(reg_wdata[15:7]))
        else $error("upper config bits not written during cool-down");

    // shutdown and cool-down sequencing
    AST_TRIP_SHUTS: assert property (@(posedge clk) disable iff (!nrst)
        st_q == fcv_pkg::FCV_ON && tif.trip |=> cooling)
        else $error("delayed trip did not shut channel");
    AST_CODE0_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        st_q == fcv_pkg::FCV_ON && shut_ev && cldn_sel == 2'h0
        |=> st_q == fcv_pkg::FCV_HOLD && !channel_enable_allowed)
        else $error("code zero shutdown did not latch off");
    AST_HOLD_STAYS: assert property (@(posedge clk) disable iff (!nrst)
        st_q == fcv_pkg::FCV_HOLD && !wr_cfg |=> st_q == fcv_pkg::FCV_HOLD)
        else $error("indefinite cool-down left without host write");
    AST_HOLD_RETRY: assert property (@(posedge clk) disable iff (!nrst)
        st_q == fcv_pkg::FCV_HOLD && wr_cfg && reg_wdata[fcv_pkg::FCV_CLDN_LSB +: 2] != 2'h0
        |=> st_q == fcv_pkg::FCV_COOL && cool_q == 26'h0000000)
        else $error("timed code did not start cool-down from hold");
    AST_TIMED_SHUT: assert property (@(posedge clk) disable iff (!nrst)
        st_q == fcv_pkg::FCV_ON && shut_ev && cldn_sel != 2'h0
        |=> st_q == fcv_pkg::FCV_COOL && cool_q == 26'h0000000)
        else $error("timed shutdown did not start cool-down");
    AST_COOL_STAYS: assert property (@(posedge clk) disable iff (!nrst)
        st_q == fcv_pkg::FCV_COOL && cool_q < cool_lim - 26'h0000001 |=> cooling)
        else $error("cool-down ended early");
    AST_COOL_ENDS: assert property (@(posedge clk) disable iff (!nrst)
        st_q == fcv_pkg::FCV_COOL && cool_q >= cool_lim - 26'h0000001
        |=> st_q == fcv_pkg::FCV_ON && channel_enable_allowed)
        else $error("cool-down did not end at its limit");

    // main scenarios
    COV_RETRY: cover property (@(posedge clk) disable iff (!nrst)
        st_q == fcv_pkg::FCV_COOL ##1 st_q == fcv_pkg::FCV_ON);
    COV_HOLD: cover property (@(posedge clk) disable iff (!nrst)
        st_q == fcv_pkg::FCV_HOLD ##1 st_q == fcv_pkg::FCV_COOL);
    COV_RACE: cover property (@(posedge clk) disable iff (!nrst) conv_valid && rd_res);
    COV_TRIP: cover property (@(posedge clk) disable iff (!nrst)
        st_q == fcv_pkg::FCV_ON && tif.trip);
    COV_LOCKED_WRITE: cover property (@(posedge clk) disable iff (!nrst)
        wr_cfg && cooling);
endmodule // fcv_top
`default_nettype wire

// [fcv_host_model.sv]
// fcv_host_model: host side of the register port.
// assumes strobes are driven on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module fcv_host_model
(
    // clock
    input  wire logic        clk,
    // register port
    output logic      [7:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // one strobe held across exactly one rising edge
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= ~w;
        @(negedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_wdata <= ~d; // released data must not look sticky
    endtask
endmodule // fcv_host_model
`default_nettype wire

// [tb.sv]
// tb: self-checking bench for fcv_top.
// assumes short cool-down parameters 20/40/80.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [9:0]  conv_value = 10'h000;
    logic        conv_valid = 1'b0;
    logic        over = 1'b0;
    logic        fuse = 1'b0;
    logic [1:0]  thr;
    logic [3:0]  trp;
    logic [2:0]  nom;
    logic        trip;
    logic        allowed;
    logic        cool;
    logic [31:0] seed = 32'hB3F5;
    logic [15:0] w;
    logic [9:0]  v;
    logic [15:0] exp_q[$];
    int          fails = 0;
    int          check_count = 0;
    int          cycles = 0;
    always #50 clk = ~clk;
    fcv_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    fcv_top #(.CLDN1_CYC(20), .CLDN2_CYC(40), .CLDN3_CYC(80)) uut (.clk(clk),
        .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_value(conv_value),
        .conv_valid(conv_valid), .over_threshold(over), .fuse_shutdown(fuse),
        .delayed_shutdown_threshold_select(thr), .trip_energy_select(trp),
        .nominal_current_select(nom), .delayed_shutdown_trip(trip),
        .channel_enable_allowed(allowed), .in_cooldown(cool));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 16'h0000);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.access(1'b1, a, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    // the oldest noted read result is matched against each taken read
    always @(posedge clk)
        if (reg_rd === 1'b1)
            chk("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 16'hDEAD, reg_rdata);
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 12000)
        begin
            fails++;
            report_and_stop();
        end
    end
    initial
    begin
        cyc(16);
        nrst = 1'b1;
        rd(8'h15, 16'h0000);
        rd(8'h14, 16'hF800);
        rd(8'h00, 16'h0000);
        seed = xorshift(seed);
        w = {2'b01, seed[13:11], 2'b00, seed[8:0]};
        wr(8'h15, w);
        rd(8'h15, w);
        chk("fields", {7'h00, w[8:0]}, {7'h00, thr, trp, nom});
        seed = xorshift(seed);
        conv_value = seed[9:0];
        conv_valid = 1'b1;
        cyc(1);
        conv_valid = 1'b0;
        rd(8'h14, {5'h1F, 1'b1, seed[9:0]});
        wr(8'h14, 16'h0000);
        rd(8'h14, {5'h1F, 1'b0, seed[9:0]});
        // conversion and clearing read on one edge: the new result must win
        v = seed[9:0];
        seed = xorshift(seed);
        fork
            rd(8'h14, {5'h1F, 1'b0, v});
            begin
                @(negedge clk);
                conv_value = seed[9:0];
                conv_valid = 1'b1;
                @(negedge clk);
                conv_valid = 1'b0;
            end
        join
        rd(8'h14, {5'h1F, 1'b1, seed[9:0]});
        over = 1'b1;
        cyc(1000);
        over = 1'b0;
        cyc(5);
        over = 1'b1;
        cyc(1998);
        chk("early trip", 16'h0001, {15'h0, allowed & ~trip});
        cyc(8);
        chk("trip", 16'h0001, {15'h0, trip});
        over = 1'b0;
        cyc(1);
        chk("cool", 16'h0001, {15'h0, cool});
        chk("off", 16'h0000, {15'h0, allowed});
        wr(8'h15, {w[15:7], ~w[6:0]});
        rd(8'h15, w);
        cyc(25);
        chk("retry", 16'h0000, {15'h0, cool});
        w[15:14] = 2'b00;
        wr(8'h15, w);
        fuse = 1'b1;
        cyc(1);
        fuse = 1'b0;
        cyc(200);
        chk("hold", 16'h0001, {15'h0, cool});
        chk("hold off", 16'h0000, {15'h0, allowed});
        w[15:14] = 2'b10;
        wr(8'h15, w);
        cyc(30);
        chk("timed", 16'h0001, {15'h0, cool});
        cyc(15);
        chk("end", 16'h0000, {15'h0, cool});
        wr(8'h15, {w[15:7], ~w[6:0]});
        rd(8'h15, {w[15:7], ~w[6:0]});
        cyc(2);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
